// ### otp_dev_model.sv
// Behavioural one-time memory that the programmer burns, verifies and reads.
module otp_dev_model #(
   parameter logic [15:0] LAST = 16'h0003,
   parameter int PW_MIN_NS = 1520,
   parameter int PW_MAX_NS = 1680,
   parameter logic [7:0] MAKER = 8'hA5, // Arbitrary value.
   parameter logic [7:0] DTYPE = 8'h3C // Arbitrary value.
) (
   // Pins and supplies from the programmer.
   input wire otp_prog_pkg::mem_pins_t pins,
   input wire otp_prog_pkg::supply_t supply,
   // Bench controls: blank array, slow address and its pulse need, bad reads.
   input wire logic wipe,
   input wire logic [15:0] weak_addr,
   input wire logic [3:0] weak_need,
   input wire logic bad_read,
   // Data pins as the device drives them.
   output logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // Array and per-address tallies of pulses, verify reads and read-backs.
   logic [7:0] mem [0:65535];
   logic [7:0] pulses [0:65535];
   logic [7:0] checks [0:65535];
   logic rb [0:65535];
   // Breaches seen, addresses still without a pulse, last verified address.
   logic [7:0] viol;
   int unpulsed;
   logic [15:0] last_chk;
   // Pins captured when a pulse starts.
   logic [15:0] p_addr;
   logic [7:0] p_data;
   time t_fall;
   logic hv;
   assign hv = (supply.vpp == otp_prog_pkg::VPP_PROG_13V0);
   // A released bus shows the inverted byte, so a stale value never matches.
   assign rd_data = (pins.ce_n || pins.data_oe) ? ~mem[pins.addr]
      : (pins.id_high_voltage_address_line && !hv)
         ? (({pins.addr[15:10], pins.addr[8:1]} == 14'h0000)
            ? (pins.addr[0] ? DTYPE : MAKER) : 8'h00)
      : ((bad_read && !hv) ? ~mem[pins.addr] : mem[pins.addr]);
   // Blank the array and clear the tallies before each run.
   always @(posedge wipe) begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'hFF;
         pulses[i] = 8'h00;
         checks[i] = 8'h00;
         rb[i] = 1'b0;
      end
      viol = 8'h00;
      unpulsed = int'(LAST) + 1;
      last_chk = 16'hFFFF;
   end
   // A falling chip enable starts a pulse or, with data released, a verify read.
   always @(negedge pins.ce_n) begin
      t_fall = $time;
      p_addr = pins.addr;
      p_data = pins.data_out;
      if (!pins.data_oe && hv) begin
         checks[pins.addr] = checks[pins.addr] + 8'h01;
         if (unpulsed != 0) viol = viol + 8'h01;
         if (pins.addr != last_chk && pins.addr != last_chk + 16'h0001) begin
            viol = viol + 8'h01;
         end
         last_chk = pins.addr;
      end
   end
   // A rising chip enable ends a pulse; only zero bits are burnt in.
   always @(posedge pins.ce_n) begin
      if (pins.data_oe && hv) begin
         if ($time - t_fall < PW_MIN_NS || $time - t_fall > PW_MAX_NS) begin
            viol = viol + 8'h01;
         end
         if (pins.addr !== p_addr || pins.data_out !== p_data) viol = viol + 8'h01;
         if (pulses[pins.addr] != 8'h00 && unpulsed != 0) viol = viol + 8'h01;
         if (pulses[pins.addr] == 8'h00) unpulsed--;
         pulses[pins.addr] = pulses[pins.addr] + 8'h01;
         // The slow address needs several pulses before its bits take.
         if (pins.addr != weak_addr || pulses[pins.addr] >= {4'h0, weak_need}) begin
            mem[pins.addr] = mem[pins.addr] & pins.data_out;
         end
      end
   end
   // Address and data must not move while a pulse is on.
   always @(pins.addr or pins.data_out) begin
      if (!pins.ce_n && pins.data_oe) viol = viol + 8'h01;
   end
   // The high supply needs the core supply already at its programming level.
   always @(supply) begin
      if (supply.vpp == otp_prog_pkg::VPP_PROG_13V0 &&
          supply.vcc != otp_prog_pkg::VCC_PROG_6V5) viol = viol + 8'h01;
   end
   // Programming starts from the first location.
   always @(posedge hv) begin
      if (pins.addr != 16'h0000) viol = viol + 8'h01;
   end
   // Read-back happens at the read supply with the programming pin low.
   always @(pins.addr or pins.ce_n) begin
      if (!pins.ce_n && !pins.data_oe && !hv && !pins.id_high_voltage_address_line &&
          supply.vcc == otp_prog_pkg::VCC_READ_5V0) rb[pins.addr] = 1'b1;
   end
endmodule

// ### otp_interval_timer.sv
// Loadable down counter that marks the end of a timed interval.
module otp_interval_timer #(
   parameter int WIDTH = 12
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Load request and count.
   input wire logic load,
   input wire logic [WIDTH-1:0] count,
   // End of interval, a one-cycle pulse.
   output logic done
);
   // Remaining cycles.
   logic [WIDTH-1:0] remain;
   logic [WIDTH-1:0] next_remain;
   // Running flag.
   logic run;
   logic next_run;
   logic next_done;

   // Count down and pulse at zero.
   always_comb begin
      next_remain = remain;
      next_run = run;
      next_done = 1'b0;
      if (load) begin
         next_remain = count - WIDTH'(1);
         next_run = 1'b1;
      end else if (run) begin
         if (remain == '0) begin
            next_run = 1'b0;
            next_done = 1'b1;
         end else begin
            next_remain = remain - WIDTH'(1);
         end
      end
   end

   // Register the counter.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remain <= '0;
         run <= 1'b0;
         done <= 1'b0;
      end else begin
         remain <= next_remain;
         run <= next_run;
         done <= next_done;
      end
   end
endmodule

// ### otp_prog_pkg.sv
// Constants, types and timing for the one-time-programmable memory programmer.
package otp_prog_pkg;
   // System clock rate in kHz (25 MHz).
   localparam int CLK_KHZ = 25000;
   // Program pulse width limits and nominal, in microseconds.
   localparam int PULSE_NOM_US = 100;
   localparam int PULSE_MIN_US = 95;
   localparam int PULSE_MAX_US = 105;
   // Setup, hold and recovery times, in microseconds.
   localparam int SETUP_US = 2;
   // Data valid from chip enable, in microseconds.
   localparam int DATA_VALID_US = 1;
   // Cycle counts derived from the rate.
   localparam int PULSE_CYC = PULSE_NOM_US * CLK_KHZ / 1000;
   localparam int PULSE_MIN_CYC = (PULSE_MIN_US * CLK_KHZ + 999) / 1000;
   localparam int PULSE_MAX_CYC = PULSE_MAX_US * CLK_KHZ / 1000;
   localparam int SETUP_CYC = (SETUP_US * CLK_KHZ + 999) / 1000;
   localparam int VALID_CYC = (DATA_VALID_US * CLK_KHZ + 999) / 1000;
   // Retry limit for a byte that fails verification.
   localparam int MAX_RETRY = 10;
   // Address and data widths.
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   // Bit position of the identification line and byte-select line.
   localparam int ID_HV_BIT = 9;
   localparam int ID_SEL_BIT = 0;
   // Default last address of the array.
   localparam logic [15:0] LAST_ADDR = 16'hFFFF;
   // Supply settings requested of the external regulators.
   typedef enum logic [1:0] {VCC_OFF, VCC_READ_5V0, VCC_PROG_6V5} vcc_level_t;
   typedef enum logic [1:0] {VPP_LOW, VPP_PROG_13V0} vpp_level_t;
   // Pins toward the memory, travelling together.
   typedef struct packed {
      logic [15:0] addr;
      logic ce_n;
      logic oe_vpp_low;
      logic id_high_voltage_address_line;
      logic [7:0] data_out;
      logic data_oe;
   } mem_pins_t;
   // Supply requests travelling together.
   typedef struct packed {
      vcc_level_t vcc;
      vpp_level_t vpp;
   } supply_t;
endpackage

// ### otp_prog_sequencer.sv
// Programmer that writes, verifies and identifies a 64K x 8 one-time memory.
// Summary of operation
// - Program each byte with one 100 us low pulse.
// - Keep every pulse within 95 to 105 us.
// - Set first address, then raise both supplies; here address and core supply are set in one cycle.
// - Core supply on first, off last.
// - First pass: one pulse each, no verify.
// - Then verify-and-reprogram loop from first address.
// - Failing byte: up to ten pulses, verify each.
// - Still failing after ten: stop, flag failure.
// - Verified byte: advance until all addresses checked.
// - Then programming pin low, core supply 5.0V.
// - Read all bytes back; pass only if all match.
// - Identification: high voltage line, select picks byte.
module otp_prog_sequencer #(
   parameter logic [15:0] LAST = otp_prog_pkg::LAST_ADDR,
   parameter int PULSE_CYCLES = otp_prog_pkg::PULSE_CYC,
   parameter int SETUP_CYCLES = otp_prog_pkg::SETUP_CYC
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic arst_n,
   // Commands: start programming, or read identification bytes.
   input wire logic start,
   input wire logic id_start,
   // Source data lookup: address asked, byte returned the next cycle.
   output logic [15:0] src_addr,
   input wire logic [7:0] src_data,
   // Memory pins.
   output otp_prog_pkg::mem_pins_t pins,
   input wire logic [7:0] data_pins_in,
   // Supply requests.
   output otp_prog_pkg::supply_t supply,
   // Status.
   output logic busy,
   output logic done,
   output logic pass,
   output logic [7:0] maker_byte,
   output logic [7:0] type_byte
);
   localparam int TW = 12;
   // Synchronised reset.
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   typedef enum logic [4:0] {
      S_IDLE, S_VCC_UP, S_VPP_UP, S_P1_SET, S_P1_PULSE, S_P1_HOLD,
      S_V_SET, S_V_READ, S_V_CMP, S_R_SET, S_R_PULSE, S_R_HOLD,
      S_VPP_DN, S_VCC_DN, S_RB_SET, S_RB_CMP,
      S_ID_SET, S_ID_READ, S_FINISH
   } state_t;

   // Sequencer state and its datapath.
   state_t state, next_state;
   logic [15:0] addr, next_addr;
   logic [3:0] tries, next_tries;
   logic [7:0] wdata, next_wdata;
   logic ok, next_ok;
   logic sel, next_sel;
   logic [7:0] next_maker, next_type;
   logic next_done;
   logic tmr_load;
   logic [TW-1:0] tmr_count;
   logic tmr_done;
   otp_prog_pkg::mem_pins_t next_pins;
   otp_prog_pkg::supply_t next_supply;

   // Shared interval timer; every wait comes from the system clock. Using one
   // timer keeps the area small at the cost of serialising all waits.
   otp_interval_timer #(.WIDTH(TW)) u_timer (
      .clk(sys_clk),
      .rst_n(rst_n),
      .load(tmr_load),
      .count(tmr_count),
      .done(tmr_done)
   );

   assign src_addr = addr;
   assign busy = (state != S_IDLE);

   // Next-state logic for the whole procedure.
   always_comb begin
      next_state = state;
      next_addr = addr;
      next_tries = tries;
      next_wdata = wdata;
      next_ok = ok;
      next_sel = sel;
      next_maker = maker_byte;
      next_type = type_byte;
      next_done = 1'b0;
      next_pins = pins;
      next_supply = supply;
      tmr_load = 1'b0;
      tmr_count = TW'(SETUP_CYCLES);
      unique case (state)
         S_IDLE: begin
            // Idle with pins quiet and the chip deselected.
            next_pins.ce_n = 1'b1;
            next_pins.data_oe = 1'b0;
            if (start) begin
               next_addr = '0;
               next_pins.addr = '0;
               next_ok = 1'b1;
               next_supply.vcc = otp_prog_pkg::VCC_PROG_6V5;
               tmr_load = 1'b1;
               next_state = S_VCC_UP;
            end else if (id_start) begin
               // Identification read at normal core supply.
               next_sel = 1'b0;
               next_supply.vcc = otp_prog_pkg::VCC_READ_5V0;
               next_supply.vpp = otp_prog_pkg::VPP_LOW;
               next_pins.oe_vpp_low = 1'b1;
               next_pins.addr = '0;
               next_pins.id_high_voltage_address_line = 1'b1;
               tmr_load = 1'b1;
               next_state = S_ID_SET;
            end
         end
         S_VCC_UP: if (tmr_done) begin
            // Programming supply follows the core supply.
            next_supply.vpp = otp_prog_pkg::VPP_PROG_13V0;
            next_pins.oe_vpp_low = 1'b0;
            tmr_load = 1'b1;
            next_state = S_VPP_UP;
         end
         S_VPP_UP: if (tmr_done) begin
            next_state = S_P1_SET;
         end
         S_P1_SET, S_R_SET: begin
            // Put address and data out, then wait the setup time.
            next_pins.addr = addr;
            next_pins.data_out = src_data;
            next_pins.data_oe = 1'b1;
            next_wdata = src_data;
            if (tmr_done) begin
               next_pins.ce_n = 1'b0;
               tmr_count = TW'(PULSE_CYCLES);
               tmr_load = 1'b1;
               next_state = (state == S_P1_SET) ? S_P1_PULSE : S_R_PULSE;
            end else if (pins.data_oe == 1'b0 || pins.addr != addr) begin
               tmr_load = 1'b1;
            end else if (next_pins.data_out != pins.data_out) begin
               tmr_load = 1'b1;
            end
         end
         S_P1_PULSE, S_R_PULSE: if (tmr_done) begin
            // End the pulse; address and data stay put for the hold time.
            next_pins.ce_n = 1'b1;
            tmr_load = 1'b1;
            next_state = (state == S_P1_PULSE) ? S_P1_HOLD : S_R_HOLD;
         end
         S_P1_HOLD: if (tmr_done) begin
            next_pins.data_oe = 1'b0;
            if (addr == LAST) begin
               next_addr = '0;
               next_tries = '0;
               next_state = S_V_SET;
            end else begin
               next_addr = addr + 16'h0001;
               next_state = S_P1_SET;
            end
            tmr_load = 1'b1;
         end
         S_V_SET: begin
            // Verify read with the chip selected and outputs released.
            next_pins.addr = addr;
            next_pins.data_oe = 1'b0;
            if (tmr_done) begin
               next_pins.ce_n = 1'b0;
               tmr_count = TW'(otp_prog_pkg::VALID_CYC);
               tmr_load = 1'b1;
               next_state = S_V_READ;
            end
         end
         S_V_READ: if (tmr_done) begin
            next_state = S_V_CMP;
         end
         S_V_CMP: begin
            next_pins.ce_n = 1'b1;
            tmr_load = 1'b1;
            if (data_pins_in == src_data) begin
               next_tries = '0;
               if (addr == LAST) begin
                  next_state = S_VPP_DN;
               end else begin
                  next_addr = addr + 16'h0001;
                  next_state = S_V_SET;
               end
            end else if (tries == 4'(otp_prog_pkg::MAX_RETRY)) begin
               next_ok = 1'b0;
               next_state = S_VPP_DN;
            end else begin
               next_tries = tries + 4'h1;
               next_state = S_R_SET;
            end
         end
         S_R_HOLD: if (tmr_done) begin
            next_pins.data_oe = 1'b0;
            tmr_load = 1'b1;
            next_state = S_V_SET;
         end
         S_VPP_DN: if (tmr_done) begin
            next_supply.vpp = otp_prog_pkg::VPP_LOW;
            next_pins.oe_vpp_low = 1'b1;
            tmr_load = 1'b1;
            next_state = S_VCC_DN;
         end
         S_VCC_DN: if (tmr_done) begin
            next_supply.vcc = otp_prog_pkg::VCC_READ_5V0;
            next_addr = '0;
            tmr_load = 1'b1;
            next_state = ok ? S_RB_SET : S_FINISH;
         end
         S_RB_SET: begin
            // Final read with both enables low.
            next_pins.addr = addr;
            next_pins.ce_n = 1'b0;
            next_pins.oe_vpp_low = 1'b0;
            if (tmr_done) begin
               next_state = S_RB_CMP;
            end
         end
         S_RB_CMP: begin
            if (data_pins_in != src_data) begin
               next_ok = 1'b0;
            end
            if (addr == LAST) begin
               next_pins.ce_n = 1'b1;
               next_pins.oe_vpp_low = 1'b1;
               next_state = S_FINISH;
            end else begin
               next_addr = addr + 16'h0001;
               tmr_load = 1'b1;
               next_state = S_RB_SET;
            end
         end
         S_ID_SET: begin
            next_pins.addr = '0;
            next_pins.addr[otp_prog_pkg::ID_SEL_BIT] = sel;
            next_pins.ce_n = 1'b0;
            next_pins.oe_vpp_low = 1'b0;
            if (tmr_done) begin
               next_state = S_ID_READ;
            end
         end
         S_ID_READ: begin
            if (sel) begin
               next_type = data_pins_in;
               next_pins.ce_n = 1'b1;
               next_pins.oe_vpp_low = 1'b1;
               next_pins.id_high_voltage_address_line = 1'b0;
               next_ok = 1'b1;
               next_state = S_FINISH;
            end else begin
               next_maker = data_pins_in;
               next_sel = 1'b1;
               tmr_load = 1'b1;
               next_state = S_ID_SET;
            end
         end
         S_FINISH: begin
            next_done = 1'b1;
            next_supply.vcc = otp_prog_pkg::VCC_OFF;
            next_state = S_IDLE;
         end
         default: next_state = S_IDLE;
      endcase
   end

   // Register the sequencer.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= S_IDLE;
         addr <= '0;
         tries <= '0;
         wdata <= '0;
         ok <= 1'b0;
         sel <= 1'b0;
         maker_byte <= '0;
         type_byte <= '0;
         done <= 1'b0;
         pins <= '{addr: 16'h0000, ce_n: 1'b1, oe_vpp_low: 1'b1,
                   id_high_voltage_address_line: 1'b0, data_out: 8'h00, data_oe: 1'b0};
         supply <= '{vcc: otp_prog_pkg::VCC_OFF, vpp: otp_prog_pkg::VPP_LOW};
      end else begin
         state <= next_state;
         addr <= next_addr;
         tries <= next_tries;
         wdata <= next_wdata;
         ok <= next_ok;
         sel <= next_sel;
         maker_byte <= next_maker;
         type_byte <= next_type;
         done <= next_done;
         pins <= next_pins;
         supply <= next_supply;
      end
   end
   assign pass = ok;

   // Helper: width of the current program pulse in cycles.
   logic [TW-1:0] pw;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pw <= '0;
      end else begin
         pw <= pins.ce_n ? '0 : pw + TW'(1);
      end
   end
   wire prog_mode = (supply.vpp == otp_prog_pkg::VPP_PROG_13V0);
   // Pulse limits scale with the configured nominal width. This way a shortened
   // pulse is judged against its own five percent band, not the full-rate one.
   localparam int PW_LO_CYC = (PULSE_CYCLES * otp_prog_pkg::PULSE_MIN_US
      + otp_prog_pkg::PULSE_NOM_US - 1) / otp_prog_pkg::PULSE_NOM_US;
   localparam int PW_HI_CYC = PULSE_CYCLES * otp_prog_pkg::PULSE_MAX_US
      / otp_prog_pkg::PULSE_NOM_US;
   // Cycles allowed from a failed byte to the programming supply going low.
   localparam int STOP_WAIT = SETUP_CYCLES + 2;

   property p_pulse_width;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(pins.ce_n) && prog_mode && pins.data_oe |->
         pw >= TW'(PW_LO_CYC) && pw <= TW'(PW_HI_CYC);
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("Pulse width out of range.");
   property p_vpp_after_vcc;
      @(posedge sys_clk) disable iff (!rst_n)
      supply.vpp == otp_prog_pkg::VPP_PROG_13V0 |-> supply.vcc == otp_prog_pkg::VCC_PROG_6V5;
   endproperty
   a_vpp_after_vcc: assert property (p_vpp_after_vcc) else $error("Vpp without Vcc.");
   property p_data_stable;
      @(posedge sys_clk) disable iff (!rst_n)
      !pins.ce_n && prog_mode && pins.data_oe |=> $stable(pins.data_out) && $stable(pins.addr);
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("Data moved in pulse.");
   property p_retry_limit;
      @(posedge sys_clk) disable iff (!rst_n)
      tries <= 4'(otp_prog_pkg::MAX_RETRY);
   endproperty
   a_retry_limit: assert property (p_retry_limit) else $error("Too many retries.");
   property p_fail_stops;
      @(posedge sys_clk) disable iff (!rst_n)
      state == S_V_CMP && data_pins_in != src_data && tries == 4'(otp_prog_pkg::MAX_RETRY)
         |=> (!ok && state == S_VPP_DN)
         ##[1:STOP_WAIT] (!ok && supply.vpp == otp_prog_pkg::VPP_LOW);
   endproperty
   a_fail_stops: assert property (p_fail_stops) else $error("Failure not flagged.");
   property p_readback_low_vpp;
      @(posedge sys_clk) disable iff (!rst_n)
      state == S_RB_CMP |-> supply.vpp == otp_prog_pkg::VPP_LOW
         && supply.vcc == otp_prog_pkg::VCC_READ_5V0;
   endproperty
   a_readback_low_vpp: assert property (p_readback_low_vpp) else $error("Bad readback supply.");
   property p_mismatch_fails;
      @(posedge sys_clk) disable iff (!rst_n)
      state == S_RB_CMP && data_pins_in != src_data |=> !ok;
   endproperty
   a_mismatch_fails: assert property (p_mismatch_fails) else $error("Mismatch not failed.");
   property p_id_line;
      @(posedge sys_clk) disable iff (!rst_n)
      state == S_ID_READ |-> pins.id_high_voltage_address_line
         && pins.addr[15:1] == 15'h0000 && pins.addr[0] == sel;
   endproperty
   a_id_line: assert property (p_id_line) else $error("Bad identification pins.");
   property p_first_addr;
      @(posedge sys_clk) disable iff (!rst_n)
      state == S_IDLE && start |=> pins.addr == 16'h0000;
   endproperty
   a_first_addr: assert property (p_first_addr) else $error("Not at first address.");
   c_pulse: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(pins.ce_n) && prog_mode);
   c_retry: cover property (@(posedge sys_clk) disable iff (!rst_n) state == S_R_PULSE);
   c_pass: cover property (@(posedge sys_clk) disable iff (!rst_n) done && pass);
   c_id: cover property (@(posedge sys_clk) disable iff (!rst_n) state == S_ID_READ && sel);
endmodule

// ### tb_top.sv
// Self-checking bench for the programming sequencer against the device model.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // Shortened counts; pulse limits are the nominal width plus or minus five percent.
   localparam logic [15:0] LAST = 16'h0003;
   localparam int PULSE = 40;
   localparam int PW_NS = PULSE * 40;
   // Clock, reset and commands.
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic start = 1'b0;
   logic id_start = 1'b0;
   // Source data and memory side.
   logic [15:0] src_addr;
   logic [7:0] src_data;
   otp_prog_pkg::mem_pins_t pins;
   logic [7:0] data_pins_in;
   otp_prog_pkg::supply_t supply;
   // Status from the sequencer.
   logic busy;
   logic done;
   logic pass;
   logic [7:0] maker_byte;
   logic [7:0] type_byte;
   // Model controls.
   logic wipe = 1'b0;
   logic [3:0] weak_need = 4'h1;
   logic bad_read = 1'b0;
   // Tallies and the source image.
   int failures = 0;
   int total_checks = 0;
   logic [7:0] src [0:3] = '{8'h5A, 8'hC3, 8'h00, 8'hF0};
   assign src_data = src[src_addr[1:0]];
   always #20 sys_clk = ~sys_clk;

   otp_prog_sequencer #(.LAST(LAST), .PULSE_CYCLES(PULSE), .SETUP_CYCLES(3)) uut (
      .sys_clk(sys_clk), .arst_n(arst_n), .start(start), .id_start(id_start),
      .src_addr(src_addr), .src_data(src_data), .pins(pins), .data_pins_in(data_pins_in),
      .supply(supply), .busy(busy), .done(done), .pass(pass), .maker_byte(maker_byte),
      .type_byte(type_byte));
   otp_dev_model #(.LAST(LAST), .PW_MIN_NS(PW_NS * 95 / 100), .PW_MAX_NS(PW_NS * 105 / 100)) dev (
      .pins(pins), .supply(supply), .wipe(wipe), .weak_addr(16'h0001),
      .weak_need(weak_need), .bad_read(bad_read), .rd_data(data_pins_in));

   // Compare one value and report a mismatch.
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Print the verdict and stop.
   task automatic end_sim();
      if (failures == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Issue one command and wait, bounded, for the done pulse.
   task automatic run(input logic id);
      int n;
      n = 0;
      @(negedge sys_clk);
      start = !id;
      id_start = id;
      @(negedge sys_clk);
      start = 1'b0;
      id_start = 1'b0;
      while (done !== 1'b1 && n < 20000) begin
         @(negedge sys_clk);
         n++;
      end
      if (done !== 1'b1) begin
         failures++;
         $display("FAIL done expected 1 seen %b", done);
         end_sim();
      end
   endtask
   // Give the model a blank array and its behaviour for the next run.
   task automatic fresh(input logic [3:0] need, input logic bad);
      @(negedge sys_clk);
      weak_need = need;
      bad_read = bad;
      wipe = 1'b1;
      @(negedge sys_clk);
      wipe = 1'b0;
   endtask
   // Outputs must be safe straight after reset.
   task automatic t_reset();
      chk("ce_n", 8'h01, {7'h00, pins.ce_n});
      chk("data_oe", 8'h00, {7'h00, pins.data_oe});
      chk("supply", 8'h00, {4'h0, supply});
      chk("busy", 8'h00, {7'h00, busy});
   endtask
   // Identification bytes come from the device, selected by the low address bit.
   task automatic t_ident();
      fresh(4'h1, 1'b0);
      run(1'b1);
      chk("id pass", 8'h01, {7'h00, pass});
      chk("maker", 8'hA5, maker_byte);
      chk("type", 8'h3C, type_byte);
   endtask
   // A clean device: one pulse and one verify per byte, then a full read-back.
   task automatic t_prog_ok();
      fresh(4'h1, 1'b0);
      run(1'b0);
      chk("pass", 8'h01, {7'h00, pass});
      for (int a = 0; a < 4; a++) begin
         chk("byte", src[a], dev.mem[a]);
         chk("pulses", 8'h01, dev.pulses[a]);
         chk("verifies", 8'h01, dev.checks[a]);
         chk("readback", 8'h01, {7'h00, dev.rb[a]});
      end
      chk("breaches", 8'h00, dev.viol);
   endtask
   // A byte that takes on its last allowed pulse still passes.
   task automatic t_retry_edge();
      fresh(4'hB, 1'b0);
      run(1'b0);
      chk("pass", 8'h01, {7'h00, pass});
      chk("pulses", 8'h0B, dev.pulses[1]);
      chk("verifies", 8'h0B, dev.checks[1]);
      chk("byte", 8'hC3, dev.mem[1]);
      chk("next verifies", 8'h01, dev.checks[2]);
      chk("breaches", 8'h00, dev.viol);
   endtask
   // One pulse more than allowed: the run stops and reports failure.
   task automatic t_retry_fail();
      fresh(4'hC, 1'b0);
      run(1'b0);
      chk("pass", 8'h00, {7'h00, pass});
      chk("pulses", 8'h0B, dev.pulses[1]);
      chk("next verifies", 8'h00, dev.checks[2]);
      chk("readback", 8'h00, {7'h00, dev.rb[0]});
      chk("vpp", 8'h00, {6'h00, supply.vpp});
      chk("breaches", 8'h00, dev.viol);
   endtask
   // Bytes that verified but read back wrong fail the device.
   task automatic t_bad_read();
      fresh(4'h1, 1'b1);
      run(1'b0);
      chk("pass", 8'h00, {7'h00, pass});
      chk("readback", 8'h01, {7'h00, dev.rb[3]});
   endtask

   // Reset for five cycles, then the scenarios in turn.
   initial begin
      repeat (5) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      t_reset();
      t_ident();
      t_prog_ok();
      t_retry_edge();
      t_retry_fail();
      t_bad_read();
      end_sim();
   end
endmodule
